/* File: sltc_chk.sv */
module sltc_chk
	import sltc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Commands
	input wire logic positioning_cmd_in,
	input wire logic interpolation_cmd_in,
	input wire logic stop_clear_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] motor_max_torque_in,
	// Results
	input wire logic signed [sltc_pkg::SLTC_TQ_W:0] torque_out,
	input wire logic origin_defined_out,
	input wire logic emergency_stop_out,
	input wire logic fwd_soft_limit_out,
	input wire logic rev_soft_limit_out,
	input wire logic decel_stop_out,
	input wire logic target_valid_out,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] fwd_cap_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	property p_stop_zero;
		emergency_stop_out |-> torque_out == '0;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("torque live in stop");
	property p_limit_stops;
		fwd_soft_limit_out || rev_soft_limit_out |-> emergency_stop_out;
	endproperty
	a_limit_stops: assert property (p_limit_stops) else $error("limit without stop");
	property p_origin_first;
		$rose(fwd_soft_limit_out) || $rose(rev_soft_limit_out) |-> $past(origin_defined_out);
	endproperty
	a_origin_first: assert property (p_origin_first) else $error("limit before origin");
	property p_stop_holds;
		emergency_stop_out && !stop_clear_in |=> emergency_stop_out;
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stop dropped alone");
	property p_torque_range;
		torque_out <= 11'sh320 && torque_out >= -11'sh320;
	endproperty
	a_torque_range: assert property (p_torque_range) else $error("torque over 800");
	property p_target_cause;
		target_valid_out |-> $past(positioning_cmd_in) || $past(interpolation_cmd_in);
	endproperty
	a_target_cause: assert property (p_target_cause) else $error("target without cmd");
	property p_decel_cause;
		$rose(decel_stop_out) |-> $past(positioning_cmd_in) || $past(interpolation_cmd_in);
	endproperty
	a_decel_cause: assert property (p_decel_cause) else $error("decel without cmd");
	property p_motor_max;
		$stable(motor_max_torque_in) |-> fwd_cap_out <= motor_max_torque_in;
	endproperty
	a_motor_max: assert property (p_motor_max) else $error("cap above motor max");
	c_estop: cover property ($rose(emergency_stop_out));
	c_decel: cover property ($rose(decel_stop_out));
	c_target: cover property (target_valid_out);
endmodule : sltc_chk

bind sltc_soft_limit_torque_clamp sltc_chk i_chk (.*);

/* File: sltc_host_model.sv */
module sltc_host_model
	import sltc_pkg::*;
(
	// Clock
	input wire logic clk_in,
	// Commands
	output logic zero_return_out,
	output logic preset_out,
	output logic origin_valid_out,
	output logic sensor_on_out,
	output logic positioning_out,
	output logic interp_out,
	output logic signed [sltc_pkg::SLTC_POS_W-1:0] target_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// One-cycle commands
	// ----
	initial begin
		{zero_return_out, preset_out, origin_valid_out, sensor_on_out} = '0;
		{positioning_out, interp_out, target_out} = '0;
	end
	task automatic send(input int op, input logic signed [31:0] tgt, input logic flag);
		@(negedge clk_in);
		target_out <= tgt;
		origin_valid_out <= flag;
		zero_return_out <= (op == 0);
		preset_out <= (op == 1);
		sensor_on_out <= (op == 2);
		positioning_out <= (op == 3);
		interp_out <= (op == 4);
		@(negedge clk_in);
		{zero_return_out, preset_out, sensor_on_out, positioning_out, interp_out} <= '0;
		// Released data is inverted so a stale sample cannot match
		origin_valid_out <= ~flag;
		target_out <= ~tgt;
	endtask : send
endmodule : sltc_host_model

/* File: sltc_pkg.sv */
package sltc_pkg;
	// ----------------------------------------
	// Travel limits
	// ----------------------------------------
	localparam int SLTC_POS_W = 32;
	localparam logic signed [31:0] SLTC_POS_MAX = 32'sh3FFF_FFFF;
	localparam logic signed [31:0] SLTC_POS_MIN = -32'sh3FFF_FFFF;
	localparam logic signed [31:0] SLTC_FWD_BOUND_RST = SLTC_POS_MAX;
	localparam logic signed [31:0] SLTC_REV_BOUND_RST = SLTC_POS_MIN;
	// ----------------------------------------
	// Selection fields
	// ----------------------------------------
	localparam logic [1:0] SLTC_SEL_BOTH_ON = 2'h0;
	localparam logic [1:0] SLTC_SEL_FWD_OFF = 2'h1;
	localparam logic [1:0] SLTC_SEL_REV_OFF = 2'h2;
	localparam logic [1:0] SLTC_SEL_BOTH_OFF = 2'h3;
	localparam logic [1:0] SLTC_SEL_RST = SLTC_SEL_BOTH_OFF;
	localparam logic SLTC_REFCHK_OFF = 1'b0;
	localparam logic SLTC_REFCHK_ON = 1'b1;
	localparam logic SLTC_REFCHK_RST = SLTC_REFCHK_OFF;
	// ----------------------------------------
	// Torque caps, percent of rated
	// ----------------------------------------
	localparam int SLTC_TQ_W = 10;
	localparam logic [9:0] SLTC_TQ_MAX = 10'h320;
	localparam logic [9:0] SLTC_TQ_ROT_RST = 10'h320;
	localparam logic [9:0] SLTC_TQ_LIN_RST = 10'h01E;
	localparam logic [9:0] SLTC_TQ_EXT_RST = 10'h064;
	// ----------------------------------------
	// Control modes and stop states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SLTC_MODE_POS = 2'h0,
		SLTC_MODE_SPD = 2'h1,
		SLTC_MODE_TRQ = 2'h2
	} sltc_mode_e;
	typedef enum logic [1:0] {
		SLTC_ST_RUN = 2'b00,
		SLTC_ST_ESTOP = 2'b01,
		SLTC_ST_DECEL = 2'b11
	} sltc_state_e;
endpackage : sltc_pkg

/* File: sltc_soft_limit_torque_clamp.sv */
// Functional notes
// - Crossing an enabled travel bound triggers emergency stop like overtravel.
// - Bounds ignored until origin set by zero return, valid preset, or sensor-on with absolute encoder.
// - Select field: 0 both on, 1 fwd off, 2 rev off, 3 both off; reset 3.
// - Signed forward and reverse bounds, range +/-1073741823, defaults max and min.
// - With checking on, out-of-range target is replaced by the bound.
// - Reference check field: 0 skip (default), 1 check positioning/interpolation targets.
// - Forward torque clamped to forward cap, reverse torque to reverse cap.
// - Rotary caps are percent of rated, 0 to 800, default 800.
// - Linear force caps percent of rated, 0 to 800, default 30.
// - Caps above motor maximum clamp to motor maximum.
// - External cap input applies in speed, position and torque control.
// - Command torque data and command cap bits apply only in speed/position.
// - Forward external input active: lesser of internal and external cap.
module sltc_soft_limit_torque_clamp
	import sltc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Configuration
	input wire logic [1:0] soft_limit_function_select_in,
	input wire logic ref_check_select_in,
	input wire logic signed [sltc_pkg::SLTC_POS_W-1:0] forward_travel_bound_in,
	input wire logic signed [sltc_pkg::SLTC_POS_W-1:0] reverse_travel_bound_in,
	input wire logic config_load_in,
	input wire logic linear_motor_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] fwd_internal_torque_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] rev_internal_torque_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] fwd_internal_force_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] rev_internal_force_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] fwd_external_torque_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] rev_external_torque_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] motor_max_torque_in,
	// Motion commands
	input wire sltc_pkg::sltc_mode_e control_mode_in,
	input wire logic zero_return_cmd_in,
	input wire logic position_preset_cmd_in,
	input wire logic origin_valid_flag_in,
	input wire logic sensor_power_on_cmd_in,
	input wire logic absolute_encoder_in,
	input wire logic positioning_cmd_in,
	input wire logic interpolation_cmd_in,
	input wire logic signed [sltc_pkg::SLTC_POS_W-1:0] target_position_in,
	input wire logic cmd_torque_cap_valid_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] cmd_torque_cap_data_in,
	input wire logic fwd_cmd_torque_cap_bit_in,
	input wire logic rev_cmd_torque_cap_bit_in,
	input wire logic stop_clear_in,
	// Feedback and pins
	input wire logic signed [sltc_pkg::SLTC_POS_W-1:0] current_position_in,
	input wire logic forward_overtravel_input_in,
	input wire logic reverse_overtravel_input_in,
	input wire logic fwd_external_cap_input_in,
	input wire logic rev_external_cap_input_in,
	// Torque path
	input wire logic signed [sltc_pkg::SLTC_TQ_W:0] torque_request_in,
	output logic signed [sltc_pkg::SLTC_TQ_W:0] torque_out,
	// Status
	output logic origin_defined_out,
	output logic emergency_stop_out,
	output logic fwd_soft_limit_out,
	output logic rev_soft_limit_out,
	output logic decel_stop_out,
	output logic signed [sltc_pkg::SLTC_POS_W-1:0] target_position_out,
	output logic target_valid_out,
	output logic [sltc_pkg::SLTC_TQ_W-1:0] fwd_cap_out,
	output logic [sltc_pkg::SLTC_TQ_W-1:0] rev_cap_out
);
	import sltc_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			pin_meta <= {rev_external_cap_input_in, fwd_external_cap_input_in,
				reverse_overtravel_input_in, forward_overtravel_input_in};
			pin_sync <= pin_meta;
		end
	end
	logic fwd_ot;
	logic rev_ot;
	logic fwd_ext;
	logic rev_ext;
	assign fwd_ot = pin_sync[0];
	assign rev_ot = pin_sync[1];
	assign fwd_ext = pin_sync[2];
	assign rev_ext = pin_sync[3];

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Reset defaults stand until software loads; loads act next cycle
	logic [1:0] sel;
	logic ref_check;
	logic signed [SLTC_POS_W-1:0] fwd_bound;
	logic signed [SLTC_POS_W-1:0] rev_bound;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sel <= SLTC_SEL_RST;
			ref_check <= SLTC_REFCHK_RST;
			fwd_bound <= SLTC_FWD_BOUND_RST;
			rev_bound <= SLTC_REV_BOUND_RST;
		end else if (config_load_in) begin
			sel <= soft_limit_function_select_in;
			ref_check <= ref_check_select_in;
			fwd_bound <= sat_pos(forward_travel_bound_in);
			rev_bound <= sat_pos(reverse_travel_bound_in);
		end
	end

	function automatic logic signed [SLTC_POS_W-1:0] sat_pos(
		input logic signed [SLTC_POS_W-1:0] v);
		if (v > SLTC_POS_MAX) begin
			sat_pos = SLTC_POS_MAX;
		end else if (v < SLTC_POS_MIN) begin
			sat_pos = SLTC_POS_MIN;
		end else begin
			sat_pos = v;
		end
	endfunction : sat_pos

	function automatic logic [SLTC_TQ_W-1:0] sat_tq(input logic [SLTC_TQ_W-1:0] v);
		sat_tq = (v > SLTC_TQ_MAX) ? SLTC_TQ_MAX : v;
	endfunction : sat_tq

	logic fwd_enabled;
	logic rev_enabled;
	assign fwd_enabled = (sel == SLTC_SEL_BOTH_ON) || (sel == SLTC_SEL_REV_OFF);
	assign rev_enabled = (sel == SLTC_SEL_BOTH_ON) || (sel == SLTC_SEL_FWD_OFF);

	// ----------------------------------------
	// Origin tracking
	// ----------------------------------------
	logic origin_defined;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			origin_defined <= 1'b0;
		end else if (zero_return_cmd_in
			|| (position_preset_cmd_in && origin_valid_flag_in)
			|| (absolute_encoder_in && sensor_power_on_cmd_in)) begin
			origin_defined <= 1'b1;
		end else if (position_preset_cmd_in) begin
			origin_defined <= 1'b0;
		end
	end
	assign origin_defined_out = origin_defined;

	// ----------------------------------------
	// Travel supervision
	// ----------------------------------------
	logic fwd_past;
	logic rev_past;
	logic target_clipped;
	assign fwd_past = origin_defined && fwd_enabled
		&& (current_position_in > fwd_bound);
	assign rev_past = origin_defined && rev_enabled
		&& (current_position_in < rev_bound);

	sltc_state_e state;
	sltc_state_e next_state;
	always_comb begin
		next_state = state;
		case (state)
			SLTC_ST_RUN: begin
				if (fwd_past || rev_past || fwd_ot || rev_ot) begin
					next_state = SLTC_ST_ESTOP;
				end else if (target_clipped) begin
					next_state = SLTC_ST_DECEL;
				end
			end
			SLTC_ST_DECEL: begin
				if (fwd_past || rev_past || fwd_ot || rev_ot) begin
					next_state = SLTC_ST_ESTOP;
				end else if (stop_clear_in) begin
					next_state = SLTC_ST_RUN;
				end
			end
			SLTC_ST_ESTOP: begin
				// Stop holds until cleared with the axis back in range
				if (stop_clear_in && !(fwd_past || rev_past || fwd_ot || rev_ot)) begin
					next_state = SLTC_ST_RUN;
				end
			end
			default: begin
				next_state = SLTC_ST_ESTOP;
			end
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= SLTC_ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			emergency_stop_out <= 1'b0;
			decel_stop_out <= 1'b0;
			fwd_soft_limit_out <= 1'b0;
			rev_soft_limit_out <= 1'b0;
		end else begin
			emergency_stop_out <= (next_state == SLTC_ST_ESTOP);
			decel_stop_out <= (next_state == SLTC_ST_DECEL);
			fwd_soft_limit_out <= fwd_past;
			rev_soft_limit_out <= rev_past;
		end
	end

	// ----------------------------------------
	// Target reference checking
	// ----------------------------------------
	logic target_cmd;
	logic check_on;
	logic tgt_over;
	logic tgt_under;
	assign target_cmd = positioning_cmd_in || interpolation_cmd_in;
	assign check_on = (ref_check == SLTC_REFCHK_ON) && origin_defined;
	assign tgt_over = check_on && fwd_enabled && (target_position_in > fwd_bound);
	assign tgt_under = check_on && rev_enabled && (target_position_in < rev_bound);
	assign target_clipped = target_cmd && (tgt_over || tgt_under);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			target_position_out <= '0;
			target_valid_out <= 1'b0;
		end else begin
			target_valid_out <= target_cmd;
			if (target_cmd) begin
				if (tgt_over) begin
					target_position_out <= fwd_bound;
				end else if (tgt_under) begin
					target_position_out <= rev_bound;
				end else begin
					target_position_out <= target_position_in;
				end
			end
		end
	end

	// ----------------------------------------
	// Torque caps
	// ----------------------------------------
	// Linear motors use force caps; the percent range is shared
	logic [SLTC_TQ_W-1:0] fwd_int;
	logic [SLTC_TQ_W-1:0] rev_int;
	logic cmd_mode_ok;
	logic [SLTC_TQ_W-1:0] fwd_cap;
	logic [SLTC_TQ_W-1:0] rev_cap;
	assign fwd_int = sat_tq(linear_motor_in ? fwd_internal_force_cap_in
		: fwd_internal_torque_cap_in);
	assign rev_int = sat_tq(linear_motor_in ? rev_internal_force_cap_in
		: rev_internal_torque_cap_in);
	assign cmd_mode_ok = (control_mode_in != SLTC_MODE_TRQ);

	sltc_torque_cap u_fwd_cap (
		.internal_cap_in(fwd_int),
		.external_cap_in(sat_tq(fwd_external_torque_cap_in)),
		.cmd_cap_in(sat_tq(cmd_torque_cap_data_in)),
		.motor_max_in(motor_max_torque_in),
		.external_active_in(fwd_ext),
		.cmd_active_in(cmd_mode_ok && cmd_torque_cap_valid_in),
		.cmd_bit_active_in(cmd_mode_ok && fwd_cmd_torque_cap_bit_in),
		.cap_out(fwd_cap)
	);
	sltc_torque_cap u_rev_cap (
		.internal_cap_in(rev_int),
		.external_cap_in(sat_tq(rev_external_torque_cap_in)),
		.cmd_cap_in(sat_tq(cmd_torque_cap_data_in)),
		.motor_max_in(motor_max_torque_in),
		.external_active_in(rev_ext),
		.cmd_active_in(cmd_mode_ok && cmd_torque_cap_valid_in),
		.cmd_bit_active_in(cmd_mode_ok && rev_cmd_torque_cap_bit_in),
		.cap_out(rev_cap)
	);

	// Torque forced to zero while stopped by emergency
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			torque_out <= '0;
			fwd_cap_out <= SLTC_TQ_ROT_RST;
			rev_cap_out <= SLTC_TQ_ROT_RST;
		end else begin
			fwd_cap_out <= fwd_cap;
			rev_cap_out <= rev_cap;
			if (next_state == SLTC_ST_ESTOP) begin
				torque_out <= '0;
			end else if (torque_request_in > $signed({1'b0, fwd_cap})) begin
				torque_out <= $signed({1'b0, fwd_cap});
			end else if (torque_request_in < -$signed({1'b0, rev_cap})) begin
				torque_out <= -$signed({1'b0, rev_cap});
			end else begin
				torque_out <= torque_request_in;
			end
		end
	end
endmodule : sltc_soft_limit_torque_clamp

/* File: sltc_tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sltc_pkg::*;
	// ----
	// Signals
	// ----
	localparam logic signed [31:0] FB = 32'sh0000_03E8;
	localparam logic signed [31:0] PP = 32'sh0000_07D0;
	logic clk_in, rst_in, config_load_in, linear_motor_in, ref_check_select_in, stop_clear_in;
	logic [1:0] soft_limit_function_select_in;
	logic signed [31:0] forward_travel_bound_in, reverse_travel_bound_in, current_position_in;
	logic [9:0] fwd_internal_torque_cap_in, rev_internal_torque_cap_in, fwd_internal_force_cap_in;
	logic [9:0] rev_internal_force_cap_in, fwd_external_torque_cap_in, rev_external_torque_cap_in;
	logic [9:0] motor_max_torque_in, cmd_torque_cap_data_in, fwd_cap_out, rev_cap_out;
	sltc_mode_e control_mode_in;
	logic absolute_encoder_in, cmd_torque_cap_valid_in, fwd_cmd_torque_cap_bit_in;
	logic rev_cmd_torque_cap_bit_in, forward_overtravel_input_in, reverse_overtravel_input_in;
	logic fwd_external_cap_input_in, rev_external_cap_input_in, decel_stop_out, target_valid_out;
	logic signed [10:0] torque_request_in, torque_out;
	logic origin_defined_out, emergency_stop_out, fwd_soft_limit_out, rev_soft_limit_out;
	logic signed [31:0] target_position_out, tg;
	logic zr, ps, ov, so, pc, ic;
	int n_mismatch = 0;
	int check_count = 0;
	sltc_soft_limit_torque_clamp i_dut (.*, .zero_return_cmd_in(zr), .position_preset_cmd_in(ps),
		.origin_valid_flag_in(ov), .sensor_power_on_cmd_in(so), .positioning_cmd_in(pc),
		.interpolation_cmd_in(ic), .target_position_in(tg));
	sltc_host_model i_host (.clk_in(clk_in), .zero_return_out(zr), .preset_out(ps),
		.origin_valid_out(ov), .sensor_on_out(so), .positioning_out(pc), .interp_out(ic),
		.target_out(tg));
	// ----
	// Tasks
	// ----
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask : tick
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cfg(input logic [1:0] s, input logic c, input logic signed [31:0] f, r);
		@(negedge clk_in);
		{soft_limit_function_select_in, ref_check_select_in} = {s, c};
		{forward_travel_bound_in, reverse_travel_bound_in} = {f, r};
		config_load_in = 1'b1;
		@(negedge clk_in);
		config_load_in = 1'b0;
	endtask : cfg
	// Clear only once every cause is gone, else the stop stands
	task automatic clr();
		@(negedge clk_in);
		stop_clear_in = 1'b1;
		tick(2);
		stop_clear_in = 1'b0;
	endtask : clr
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	// ----
	// Clock, watchdog, tests
	// ----
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		final_report();
	end
	initial begin
		{rst_in, config_load_in, linear_motor_in, ref_check_select_in, stop_clear_in} = 5'h1_0;
		{absolute_encoder_in, cmd_torque_cap_valid_in, fwd_cmd_torque_cap_bit_in} = '0;
		{rev_cmd_torque_cap_bit_in, forward_overtravel_input_in, reverse_overtravel_input_in} = '0;
		{fwd_external_cap_input_in, rev_external_cap_input_in, cmd_torque_cap_data_in} = '0;
		soft_limit_function_select_in = 2'h3;
		control_mode_in = SLTC_MODE_POS;
		{forward_travel_bound_in, reverse_travel_bound_in, current_position_in} = '0;
		{fwd_internal_torque_cap_in, rev_internal_torque_cap_in, motor_max_torque_in} = {3{10'h320}};
		{fwd_internal_force_cap_in, rev_internal_force_cap_in} = {2{SLTC_TQ_LIN_RST}};
		{fwd_external_torque_cap_in, rev_external_torque_cap_in} = {2{SLTC_TQ_EXT_RST}};
		torque_request_in = 11'sh064;
		tick(8);
		chk("rst_fwd_cap", SLTC_TQ_ROT_RST, fwd_cap_out);
		chk("rst_rev_cap", SLTC_TQ_ROT_RST, rev_cap_out);
		chk("rst_estop", 1'b0, emergency_stop_out);
		chk("rst_torque", 32'h0, torque_out);
		rst_in = 1'b0;
		cfg(2'h0, 1'b0, FB, -FB);
		current_position_in = PP;
		tick(3);
		chk("estop_no_origin", 1'b0, emergency_stop_out);
		current_position_in = '0;
		i_host.send(0, '0, 1'b0);
		chk("origin_zero_return_cmd", 1'b1, origin_defined_out);
		$display("test reset and origin done");
		for (int s = 0; s < 4; s++) begin
			cfg(2'(s), 1'b0, FB, -FB);
			current_position_in = PP;
			tick(3);
			chk("fwd_limit", (s == 0 || s == 2), fwd_soft_limit_out);
			chk("torque_stop", (s == 0 || s == 2) ? 32'h0 : 32'h64, torque_out);
			current_position_in = '0;
			clr();
			current_position_in = -PP;
			tick(3);
			chk("rev_limit", s < 2, rev_soft_limit_out);
			chk("rev_stop", s < 2, emergency_stop_out);
			current_position_in = '0;
			clr();
		end
		cfg(2'h0, 1'b1, FB, -FB);
		current_position_in = FB;
		forward_overtravel_input_in = 1'b1;
		tick(4);
		chk("ot_stop", 1'b1, emergency_stop_out);
		chk("at_bound", 1'b0, fwd_soft_limit_out);
		forward_overtravel_input_in = 1'b0;
		tick(3);
		clr();
		$display("test limits done");
		i_host.send(3, 32'sh0000_1388, 1'b0);
		chk("tgt_valid", 1'b1, target_valid_out);
		chk("tgt_fwd", FB, target_position_out);
		chk("decel", 1'b1, decel_stop_out);
		i_host.send(4, -32'sh0000_1388, 1'b0);
		chk("tgt_rev", -FB, target_position_out);
		clr();
		i_host.send(3, FB, 1'b0);
		chk("tgt_edge", 1'b0, decel_stop_out);
		cfg(2'h0, 1'b0, FB, -FB);
		i_host.send(4, 32'sh0000_1388, 1'b0);
		chk("tgt_nochk", 32'h0000_1388, target_position_out);
		cfg(2'h0, 1'b1, 32'sh7FFF_FFFF, 32'sh8000_0000);
		i_host.send(3, 32'sh7FFF_FFFF, 1'b0);
		chk("tgt_max", SLTC_POS_MAX, target_position_out);
		i_host.send(3, 32'sh8000_0000, 1'b0);
		chk("tgt_min", SLTC_POS_MIN, target_position_out);
		clr();
		i_host.send(1, '0, 1'b0);
		chk("preset_off", 1'b0, origin_defined_out);
		i_host.send(1, '0, 1'b1);
		chk("preset_on", 1'b1, origin_defined_out);
		i_host.send(1, '0, 1'b0);
		absolute_encoder_in = 1'b1;
		i_host.send(2, '0, 1'b0);
		chk("sensor_on", 1'b1, origin_defined_out);
		$display("test targets done");
		{fwd_internal_torque_cap_in, rev_internal_torque_cap_in} = {10'h12C, 10'h0C8};
		torque_request_in = 11'sh1F4;
		tick(3);
		chk("torque_fwd", 32'h12C, torque_out);
		torque_request_in = -11'sh1F4;
		tick(3);
		chk("torque_rev", -32'sh0C8, torque_out);
		fwd_external_cap_input_in = 1'b1;
		tick(5);
		chk("ext_cap", 10'h064, fwd_cap_out);
		control_mode_in = SLTC_MODE_TRQ;
		tick(3);
		chk("ext_trq", 10'h064, fwd_cap_out);
		fwd_external_cap_input_in = 1'b0;
		{cmd_torque_cap_valid_in, cmd_torque_cap_data_in} = {1'b1, 10'h03C};
		tick(5);
		chk("cmd_trq", 10'h12C, fwd_cap_out);
		control_mode_in = SLTC_MODE_SPD;
		tick(3);
		chk("cmd_spd", 10'h03C, fwd_cap_out);
		{cmd_torque_cap_valid_in, fwd_cmd_torque_cap_bit_in} = 2'h1;
		tick(3);
		chk("bit_spd", 10'h064, fwd_cap_out);
		control_mode_in = SLTC_MODE_TRQ;
		tick(3);
		chk("bit_trq", 10'h12C, fwd_cap_out);
		{fwd_cmd_torque_cap_bit_in, linear_motor_in} = 2'h1;
		tick(3);
		chk("force_cap", SLTC_TQ_LIN_RST, rev_cap_out);
		{linear_motor_in, motor_max_torque_in} = {1'b0, 10'h096};
		tick(3);
		chk("motor_max", 10'h096, fwd_cap_out);
		{fwd_internal_torque_cap_in, motor_max_torque_in} = {10'h3FF, 10'h320};
		tick(3);
		chk("cap_sat", 10'h320, fwd_cap_out);
		control_mode_in = SLTC_MODE_POS;
		rev_external_cap_input_in = 1'b1;
		tick(5);
		chk("rev_ext_cap", 10'h064, rev_cap_out);
		{rev_external_cap_input_in, cmd_torque_cap_valid_in} = 2'h1;
		tick(5);
		chk("cmd_pos", 10'h03C, rev_cap_out);
		{cmd_torque_cap_valid_in, rev_cmd_torque_cap_bit_in} = 2'h1;
		tick(3);
		chk("rev_bit", 10'h064, rev_cap_out);
		reverse_overtravel_input_in = 1'b1;
		tick(4);
		chk("rev_ot", 1'b1, emergency_stop_out);
		chk("rev_ot_torque", 32'h0, torque_out);
		reverse_overtravel_input_in = 1'b0;
		tick(3);
		clr();
		chk("ot_clear", 1'b0, emergency_stop_out);
		$display("test caps done");
		final_report();
	end
endmodule : tb

/* File: sltc_torque_cap.sv */
module sltc_torque_cap
	import sltc_pkg::*;
(
	// Caps
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] internal_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] external_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] cmd_cap_in,
	input wire logic [sltc_pkg::SLTC_TQ_W-1:0] motor_max_in,
	// Qualifiers
	input wire logic external_active_in,
	input wire logic cmd_active_in,
	input wire logic cmd_bit_active_in,
	// Result
	output logic [sltc_pkg::SLTC_TQ_W-1:0] cap_out
);
	import sltc_pkg::*;

	function automatic logic [SLTC_TQ_W-1:0] tq_min(input logic [SLTC_TQ_W-1:0] a,
		input logic [SLTC_TQ_W-1:0] b);
		tq_min = (a < b) ? a : b;
	endfunction : tq_min

	always_comb begin
		cap_out = internal_cap_in;
		if (external_active_in) begin
			cap_out = tq_min(cap_out, external_cap_in);
		end
		if (cmd_active_in) begin
			cap_out = tq_min(cap_out, cmd_cap_in);
		end
		if (cmd_bit_active_in) begin
			cap_out = tq_min(cap_out, external_cap_in);
		end
		cap_out = tq_min(cap_out, motor_max_in);
	end
endmodule : sltc_torque_cap
